// ===== hdl/nvac_ctrl.sv
// Indirect access controller for the data EEPROM and program flash reads.
//
// Summary of operation
// - 256 data bytes, low address, low data.
// - Program word joins data and address pairs.
// - Program word address range limited per variant.
// - Byte write erases then stores automatically.
// - Internal timer alone ends a write.
// - Program reads always allowed; writes protected.
// - Space select bit 7, data at reset.
// - Strobes only set by software, hardware clears.
// - Write permit clear at reset gates strobe.
// - Software, reset and warm reset clear permit; clearing harmless.
// - Abort flag set by warm reset mid-write.
// - Completion clears strobe, sets sticky done flag.
// - Unlock port stores nothing, reads zero.
// - Write needs 55h, AAh, then strobe.
// - Data byte appears next cycle and holds.
// - Program read uses second instruction, suppresses it.
// - Write strobe in program space cancels itself.
// - High data keeps six bits, top reads zero.
// - High address keeps bits 4..0 only.
`timescale 1ns/1ps
`include "nvac_params.svh"

module nvac_ctrl #(
  parameter int unsigned WRITE_TIME_US = `NVAC_WRITE_TIME_US
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   master_clear_i,
  input  wire logic                   watchdog_unit_i,
  input  wire logic                   brownout_reset_i,
  input  wire logic                   cpu_instr_i,
  input  wire nvac_pkg::nvac_sel_t    reg_sel_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  input  wire nvac_pkg::nvac_byte_t   reg_wdata_i,
  output nvac_pkg::nvac_byte_t        reg_rdata_o,
  input  wire logic                   write_done_clr_i,
  output logic                        write_done_o,
  output logic                        write_busy_o,
  output nvac_pkg::nvac_pm_addr_t     pm_addr_o,
  output logic                        pm_rd_o,
  input  wire nvac_pkg::nvac_pm_word_t pm_rdata_i,
  output logic                        suppress_instr_o
);
  import nvac_pkg::*;

  // Write time in clock cycles, never below two so each phase has a cycle.
  localparam int unsigned WRITE_RAW    = WRITE_TIME_US * `NVAC_CLK_MHZ;
  localparam int unsigned WRITE_CYCLES = (WRITE_RAW < 2) ? 2 : WRITE_RAW;
  localparam logic [19:0] PHASE_LAST   = 20'(WRITE_CYCLES / 2 - 1);

  // Register write decode, used by every register owner.
  function automatic logic hit(input nvac_sel_t sel, input nvac_sel_t code, input logic stb);
    hit = stb && (sel == code);
  endfunction

  // Reset release and synchronised reset sources.
  logic [1:0]        rst_sync_r;     // Release pipeline for the power-on reset.
  logic              rst_n_r;        // Reset copy used by the whole block.
  logic [2:0]        src_meta_r;     // First stage for the three reset sources.
  logic [2:0]        src_sync_r;     // Second stage, safe to read.
  logic              soft_rst;       // Master clear, watchdog or brown-out seen.

  // Software-visible registers.
  nvac_byte_t        data_low_r;     // Low data byte.
  nvac_byte_t        addr_low_r;     // Low address byte.
  nvac_byte_t        data_high_r;    // High data byte, six bits kept.
  nvac_byte_t        addr_high_r;    // High address byte, five bits kept.
  logic              space_r;        // One selects program space.
  logic              permit_r;       // Write permit.
  logic              abort_r;        // Write abort flag.
  logic              wr_r;           // Write strobe.
  logic              rd_r;           // Read strobe.

  // Sequencers and storage.
  nvac_ustate_t      ustate_r;       // Unlock tracker.
  nvac_wstate_t      wstate_r;       // Byte write sequencer.
  nvac_pstate_t      pstate_r;       // Program read sequencer.
  logic [19:0]       timer_r;        // Write phase timer.
  nvac_byte_t        wr_addr_r;      // Address latched at write start.
  nvac_byte_t        wr_data_r;      // Data latched at write start.
  nvac_byte_t        mem_r [`NVAC_DATA_BYTES]; // Data EEPROM array.

  // Decoded strobes.
  logic              ctrl_wr;        // Software write to the control register.
  logic              wr_start;       // A byte write begins this cycle.
  logic              wr_finish;      // The byte write ends this cycle.
  logic              data_rd_go;     // Data-space read strobe this cycle.
  logic              pm_rd_go;       // Program-space read strobe this cycle.
  logic              pm_capture;     // Program word captured this cycle.
  nvac_byte_t        rdata_nxt;      // Read data before its output flop.

  // Release the external reset through two flops so that no flop leaves reset
  // on a different edge from its neighbours.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_r = rst_sync_r[1];

  // Reset sources come from pins and other units, so each passes two flops.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      src_meta_r <= 3'b000;
      src_sync_r <= 3'b000;
    end else begin
      src_meta_r <= {brownout_reset_i, watchdog_unit_i, master_clear_i};
      src_sync_r <= src_meta_r;
    end
  end
  assign soft_rst = |src_sync_r;

  // Control decode.
  assign ctrl_wr    = hit(reg_sel_i, `NVAC_SEL_CONTROL, reg_wr_i) && !soft_rst;
  // A write starts only from the armed tracker, with permit set and data space chosen.
  assign wr_start   = ctrl_wr && reg_wdata_i[`NVAC_BIT_WR] && !wr_r
                      && (ustate_r == NVAC_U_ARMED) && permit_r
                      && !reg_wdata_i[`NVAC_BIT_SPACE];
  assign wr_finish  = (wstate_r == NVAC_W_PROGRAM) && (timer_r == 20'h00000)
                      && !soft_rst;
  assign data_rd_go = ctrl_wr && reg_wdata_i[`NVAC_BIT_RD] && !reg_wdata_i[`NVAC_BIT_SPACE];
  assign pm_rd_go   = ctrl_wr && reg_wdata_i[`NVAC_BIT_RD] && reg_wdata_i[`NVAC_BIT_SPACE]
                      && (pstate_r == NVAC_P_IDLE);
  assign pm_capture = (pstate_r == NVAC_P_FETCH) && cpu_instr_i && !soft_rst;

  // Control register. Strobes only rise on software writes and only fall by hardware.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      space_r  <= 1'b0;
      permit_r <= 1'b0;
      abort_r  <= 1'b0;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end else if (soft_rst) begin
      // A warm reset flags a write that it cuts short, and clears the rest.
      space_r  <= 1'b0;
      permit_r <= 1'b0;
      abort_r  <= (wstate_r != NVAC_W_IDLE) || abort_r;
      wr_r     <= 1'b0;
      rd_r     <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        space_r  <= reg_wdata_i[`NVAC_BIT_SPACE];
        // Only software touches the permit, so a running write ignores it.
        permit_r <= reg_wdata_i[`NVAC_BIT_PERMIT];
        abort_r  <= reg_wdata_i[`NVAC_BIT_ABORT];
      end
      if (wr_start) begin
        wr_r <= 1'b1;
      end else if (wr_finish) begin
        wr_r    <= 1'b0;
        abort_r <= 1'b0;
      end
      // A data read finishes at once, so its strobe never shows as set.
      if (pm_rd_go) begin
        rd_r <= 1'b1;
      end else if (pm_capture) begin
        rd_r <= 1'b0;
      end
    end
  end

  // Unlock tracker. Any register write other than the next expected step or a 55h key
  // drops it to idle; instructions that write no register leave it alone,
  // because the key values themselves must be loaded between the two writes.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ustate_r <= NVAC_U_IDLE;
    end else if (soft_rst) begin
      ustate_r <= NVAC_U_IDLE;
    end else if (hit(reg_sel_i, `NVAC_SEL_UNLOCK, reg_wr_i)) begin
      if (reg_wdata_i == `NVAC_KEY_FIRST) begin
        ustate_r <= NVAC_U_GOT55;
      end else if (reg_wdata_i == `NVAC_KEY_SECOND && ustate_r == NVAC_U_GOT55) begin
        ustate_r <= NVAC_U_ARMED;
      end else begin
        ustate_r <= NVAC_U_IDLE;
      end
    end else if (reg_wr_i) begin
      // The strobe write consumes the key whether or not it starts a write.
      ustate_r <= NVAC_U_IDLE;
    end
  end

  // Byte write sequencer: erase phase then program phase, each half the time.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wstate_r  <= NVAC_W_IDLE;
      timer_r   <= 20'h00000;
      wr_addr_r <= `NVAC_BYTE_RESET;
      wr_data_r <= `NVAC_BYTE_RESET;
    end else if (soft_rst) begin
      wstate_r <= NVAC_W_IDLE;
      timer_r  <= 20'h00000;
    end else begin
      unique case (wstate_r)
        NVAC_W_IDLE: begin
          if (wr_start) begin
            // Latch the target so later register writes cannot disturb it.
            wstate_r  <= NVAC_W_ERASE;
            timer_r   <= PHASE_LAST;
            wr_addr_r <= addr_low_r;
            wr_data_r <= data_low_r;
          end
        end
        NVAC_W_ERASE: begin
          if (timer_r == 20'h00000) begin
            wstate_r <= NVAC_W_PROGRAM;
            timer_r  <= PHASE_LAST;
          end else begin
            timer_r <= timer_r - 20'h00001;
          end
        end
        NVAC_W_PROGRAM: begin
          if (timer_r == 20'h00000) begin
            wstate_r <= NVAC_W_IDLE;
          end else begin
            timer_r <= timer_r - 20'h00001;
          end
        end
        default: begin
          wstate_r <= NVAC_W_IDLE;
          timer_r  <= 20'h00000;
        end
      endcase
    end
  end

  // Data array. Left without reset: it models nonvolatile cells.
  always_ff @(posedge clk_i) begin
    if (wstate_r == NVAC_W_ERASE && timer_r == 20'h00000 && !soft_rst) begin
      mem_r[wr_addr_r] <= `NVAC_ERASED_BYTE;
    end else if (wr_finish) begin
      mem_r[wr_addr_r] <= wr_data_r;
    end
  end

  // Program read sequencer. The instruction after the strobe runs normally;
  // the one after that is spent on the flash fetch and suppressed.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pstate_r         <= NVAC_P_IDLE;
      pm_rd_o          <= 1'b0;
      suppress_instr_o <= 1'b0;
      pm_addr_o        <= 13'h0000;
    end else if (soft_rst) begin
      pstate_r         <= NVAC_P_IDLE;
      pm_rd_o          <= 1'b0;
      suppress_instr_o <= 1'b0;
    end else begin
      unique case (pstate_r)
        NVAC_P_IDLE: begin
          if (pm_rd_go) begin
            pstate_r  <= NVAC_P_WAIT;
            // Word address joins the high and low bytes, cut to the array size.
            pm_addr_o <= {addr_high_r[4:0], addr_low_r} & `NVAC_PM_ADDR_MASK;
          end
        end
        NVAC_P_WAIT: begin
          if (cpu_instr_i) begin
            // Program reads ignore self-write protection entirely.
            pstate_r         <= NVAC_P_FETCH;
            pm_rd_o          <= 1'b1;
            suppress_instr_o <= 1'b1;
          end
        end
        NVAC_P_FETCH: begin
          if (cpu_instr_i) begin
            pstate_r         <= NVAC_P_IDLE;
            pm_rd_o          <= 1'b0;
            suppress_instr_o <= 1'b0;
          end
        end
        default: begin
          pstate_r         <= NVAC_P_IDLE;
          pm_rd_o          <= 1'b0;
          suppress_instr_o <= 1'b0;
        end
      endcase
    end
  end

  // Data and address pairs. Data reads overwrite the low data byte, program reads the pair; software writes win
  // only when no read lands in the same cycle, which a single CPU cannot do.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      data_low_r  <= `NVAC_BYTE_RESET;
      data_high_r <= `NVAC_BYTE_RESET;
      addr_low_r  <= `NVAC_BYTE_RESET;
      addr_high_r <= `NVAC_BYTE_RESET;
    end else begin
      if (data_rd_go) begin
        data_low_r <= mem_r[addr_low_r];
      end else if (pm_capture) begin
        data_low_r <= pm_rdata_i[7:0];
      end else if (hit(reg_sel_i, `NVAC_SEL_DATA_LOW, reg_wr_i)) begin
        data_low_r <= reg_wdata_i;
      end
      if (pm_capture) begin
        data_high_r <= {2'b00, pm_rdata_i[13:8]};
      end else if (hit(reg_sel_i, `NVAC_SEL_DATA_HIGH, reg_wr_i)) begin
        data_high_r <= reg_wdata_i & `NVAC_DATAH_MASK;
      end
      if (hit(reg_sel_i, `NVAC_SEL_ADDR_LOW, reg_wr_i)) begin
        addr_low_r <= reg_wdata_i;
      end
      if (hit(reg_sel_i, `NVAC_SEL_ADDR_HIGH, reg_wr_i)) begin
        addr_high_r <= reg_wdata_i & `NVAC_ADDRH_MASK;
      end
    end
  end

  // Read data mux; unimplemented bits and the unlock port read zero.
  always_comb begin
    rdata_nxt = `NVAC_ZERO_BYTE;
    unique case (reg_sel_i)
      `NVAC_SEL_DATA_LOW:  rdata_nxt = data_low_r;
      `NVAC_SEL_ADDR_LOW:  rdata_nxt = addr_low_r;
      `NVAC_SEL_DATA_HIGH: rdata_nxt = data_high_r;
      `NVAC_SEL_ADDR_HIGH: rdata_nxt = addr_high_r;
      `NVAC_SEL_CONTROL:   rdata_nxt = {space_r, 3'b000, abort_r, permit_r, wr_r, rd_r};
      `NVAC_SEL_UNLOCK:    rdata_nxt = `NVAC_ZERO_BYTE;
      default:             rdata_nxt = `NVAC_ZERO_BYTE;
    endcase
  end

  // Registered read port: data shows one edge after the read request.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= `NVAC_ZERO_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // Sticky completion flag; a completion in the clearing cycle wins.
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      write_done_o <= 1'b0;
      write_busy_o <= 1'b0;
    end else begin
      if (wr_finish) begin
        write_done_o <= 1'b1;
      end else if (write_done_clr_i) begin
        write_done_o <= 1'b0;
      end
      write_busy_o <= wr_start || (wr_r && !wr_finish && !soft_rst);
    end
  end

  a_wr_needs_permit: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    $rose(wr_r) |-> $past(permit_r)) else $error("write strobe rose without permit");
  a_wr_unlock_order: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    $rose(wr_r) |-> $past(ustate_r == NVAC_U_ARMED)) else $error("write without unlock");
  a_wr_data_space: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (ctrl_wr && reg_wdata_i[`NVAC_BIT_SPACE]) |=> !$rose(wr_r))
    else $error("write strobe set in program space");
  a_wr_done_pair: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    wr_finish |=> (!wr_r && write_done_o && !abort_r)) else $error("completion mishandled");
  a_wr_strobe_held: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (wr_r && !wr_finish && !soft_rst) |=> wr_r) else $error("write strobe fell early");
  a_erase_first: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    wr_start |=> (wstate_r == NVAC_W_ERASE) ##1 (wstate_r == NVAC_W_ERASE || soft_rst
    || wstate_r == NVAC_W_PROGRAM)) else $error("write did not begin with erase");
  a_data_read_next: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    data_rd_go |=> (data_low_r == $past(mem_r[addr_low_r]))) else $error("data read late");
  a_unlock_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (reg_rd_i && reg_sel_i == `NVAC_SEL_UNLOCK) |=> (reg_rdata_o == `NVAC_ZERO_BYTE))
    else $error("unlock port read nonzero");
  a_abort_on_reset: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (soft_rst && wstate_r != NVAC_W_IDLE) |=> (abort_r && !wr_r)) else $error("abort not flagged");
  a_permit_kept: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (!soft_rst && !ctrl_wr) |=> $stable(permit_r)) else $error("permit changed by hardware");
  a_pm_read_slot: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    $rose(pm_rd_o) |-> (suppress_instr_o && rd_r && space_r)) else $error("fetch slot wrong");
  a_high_bits_zero: assert property (@(posedge clk_i) disable iff (!rst_n_r)
    (data_high_r[7:6] == 2'b00) && (addr_high_r[7:5] == 3'b000)) else $error("high bits set");
endmodule

// ===== hdl/nvac_params.svh
// Constants of the nonvolatile access controller: register indices, fields, resets, timing.
`ifndef NVAC_PARAMS_SVH
`define NVAC_PARAMS_SVH

// Register select codes on the special function register port.
`define NVAC_SEL_DATA_LOW     3'h0
`define NVAC_SEL_ADDR_LOW     3'h1
`define NVAC_SEL_DATA_HIGH    3'h2
`define NVAC_SEL_ADDR_HIGH    3'h3
`define NVAC_SEL_CONTROL      3'h4
`define NVAC_SEL_UNLOCK       3'h5

// Control register bit positions.
`define NVAC_BIT_RD           0
`define NVAC_BIT_WR           1
`define NVAC_BIT_PERMIT       2
`define NVAC_BIT_ABORT        3
`define NVAC_BIT_SPACE        7

// Implemented bit masks and reset values.
`define NVAC_DATAH_MASK       8'h3f
`define NVAC_ADDRH_MASK       8'h1f
`define NVAC_PM_ADDR_MASK     13'h0fff
`define NVAC_BYTE_RESET       8'h00
`define NVAC_ERASED_BYTE      8'hff
`define NVAC_ZERO_BYTE        8'h00

// Unlock key values.
`define NVAC_KEY_FIRST        8'h55
`define NVAC_KEY_SECOND       8'haa

// Data memory size in bytes.
`define NVAC_DATA_BYTES       256

// Clock rate and the default byte write time.
`define NVAC_CLK_MHZ          10
`define NVAC_WRITE_TIME_US    4000

`endif

// ===== hdl/nvac_pkg.sv
// Types shared by the nonvolatile access controller.
package nvac_pkg;
  // Register select code and byte carrier.
  typedef logic [2:0] nvac_sel_t;
  typedef logic [7:0] nvac_byte_t;
  typedef logic [12:0] nvac_pm_addr_t;
  typedef logic [13:0] nvac_pm_word_t;

  // Byte write sequencer states.
  typedef enum logic [1:0] {
    NVAC_W_IDLE    = 2'b00,
    NVAC_W_ERASE   = 2'b01,
    NVAC_W_PROGRAM = 2'b10
  } nvac_wstate_t;

  // Unlock sequence tracker states.
  typedef enum logic [1:0] {
    NVAC_U_IDLE  = 2'b00,
    NVAC_U_GOT55 = 2'b01,
    NVAC_U_ARMED = 2'b10
  } nvac_ustate_t;

  // Program memory read states.
  typedef enum logic [1:0] {
    NVAC_P_IDLE  = 2'b00,
    NVAC_P_WAIT  = 2'b01,
    NVAC_P_FETCH = 2'b10
  } nvac_pstate_t;
endpackage

// ===== verification/nvac_flash_model.sv
// Behavioural program flash that answers the controller's word fetches.
`timescale 1ns/1ps
module nvac_flash_model (
  input  wire nvac_pkg::nvac_pm_addr_t pm_addr_i,
  input  wire logic                    pm_rd_i,
  output nvac_pkg::nvac_pm_word_t      pm_rdata_o
);
  import nvac_pkg::*;
  // Content is a fixed scramble of the word address. Outside a fetch the bus
  // shows the inverse, so a capture at the wrong moment cannot pass.
  assign pm_rdata_o = pm_rd_i ? ({1'b0, pm_addr_i} ^ 14'h2a5c)
                              : ~({1'b0, pm_addr_i} ^ 14'h2a5c);
endmodule

// ===== verification/testbench.sv
// Register-level testbench of the nonvolatile access controller.
`timescale 1ns/1ps
`include "nvac_params.svh"
module testbench;
  import nvac_pkg::*;
  logic          clk, rst_n, instr, rwr, rrd, dclr, done, busy, pmrd, supp;
  logic [2:0]    warm;           // Master clear, watchdog and brown-out requests.
  nvac_sel_t     sel;
  nvac_byte_t    wdat, rdat;
  nvac_pm_addr_t pmaddr;
  nvac_pm_word_t pmdat;
  int            mismatches, check_count;
  // A one-microsecond write keeps each byte write at ten clocks.
  nvac_ctrl #(.WRITE_TIME_US(1)) u_dut (.clk_i(clk), .rst_n_i(rst_n), .master_clear_i(warm[0]),
    .watchdog_unit_i(warm[1]), .brownout_reset_i(warm[2]), .cpu_instr_i(instr), .reg_sel_i(sel),
    .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
    .write_done_clr_i(dclr), .write_done_o(done), .write_busy_o(busy), .pm_addr_o(pmaddr),
    .pm_rd_o(pmrd), .pm_rdata_i(pmdat), .suppress_instr_o(supp));
  nvac_flash_model u_flash (.pm_addr_i(pmaddr), .pm_rd_i(pmrd), .pm_rdata_o(pmdat));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One register write; the strobe drops at the next edge.
  task automatic wr(input nvac_sel_t s, input nvac_byte_t d);
    @(posedge clk);
    sel <= s;
    wdat <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  // Read a register and compare once the registered answer has landed.
  task automatic rc(input nvac_sel_t s, input nvac_byte_t e);
    @(posedge clk);
    sel <= s;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask
  // Two unlock writes followed by a control write.
  task automatic arm(input nvac_byte_t a, input nvac_byte_t b, input nvac_byte_t c);
    wr(`NVAC_SEL_UNLOCK, a);
    wr(`NVAC_SEL_UNLOCK, b);
    wr(`NVAC_SEL_CONTROL, c);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The tests need under a thousand clocks; the watchdog allows five times that.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    {rst_n, rwr, rrd, dclr} = '0;
    warm = '0;
    instr = 1'b1;
    sel = '0;
    wdat = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(`NVAC_SEL_DATA_LOW, 8'h00);
    wr(`NVAC_SEL_UNLOCK, 8'h55);
    rc(`NVAC_SEL_UNLOCK, 8'h00);
    wr(`NVAC_SEL_DATA_HIGH, 8'hff);
    rc(`NVAC_SEL_DATA_HIGH, 8'h3f);
    wr(`NVAC_SEL_ADDR_HIGH, 8'hfa);
    rc(`NVAC_SEL_ADDR_HIGH, 8'h1a);
    arm(8'h55, 8'haa, 8'h02);
    rc(`NVAC_SEL_CONTROL, 8'h00);
    $display("test registers done");
    wr(`NVAC_SEL_ADDR_LOW, 8'h5a);
    wr(`NVAC_SEL_DATA_LOW, 8'hc3);
    // The abort flag is set by software first, so completion must clear it.
    wr(`NVAC_SEL_CONTROL, 8'h0c);
    arm(8'h55, 8'haa, 8'h0e);
    rc(`NVAC_SEL_CONTROL, 8'h0e);
    chk(busy, 1'b1);
    // Clearing the permit and writing 0 to the strobe must not end the write.
    wr(`NVAC_SEL_CONTROL, 8'h08);
    rc(`NVAC_SEL_CONTROL, 8'h0a);
    // Busy is looked at a little after each edge, once it has settled.
    for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(done, 1'b1);
    rc(`NVAC_SEL_CONTROL, 8'h00);
    chk(done, 1'b1);
    @(posedge clk);
    dclr <= 1'b1;
    @(posedge clk);
    dclr <= 1'b0;
    @(posedge clk);
    #1;
    chk(done, 1'b0);
    wr(`NVAC_SEL_DATA_LOW, 8'h00);
    wr(`NVAC_SEL_CONTROL, 8'h01);
    rc(`NVAC_SEL_DATA_LOW, 8'hc3);
    $display("test data write done");
    // Keys in the wrong order, then a wrong key value written to the unlock port between the keys.
    wr(`NVAC_SEL_CONTROL, 8'h04);
    arm(8'haa, 8'h55, 8'h06);
    rc(`NVAC_SEL_CONTROL, 8'h04);
    wr(`NVAC_SEL_UNLOCK, 8'h55);
    arm(8'h00, 8'haa, 8'h06);
    rc(`NVAC_SEL_CONTROL, 8'h04);
    $display("test unlock done");
    wr(`NVAC_SEL_ADDR_LOW, 8'h34);
    wr(`NVAC_SEL_CONTROL, 8'h81);
    // Instruction ends are spread out, so the fetch must wait for each of them.
    instr <= 1'b0;
    @(posedge clk);
    instr <= 1'b1;
    #1;
    chk({pmrd, supp}, 2'b00);
    @(posedge clk);
    instr <= 1'b0;
    #1;
    chk({pmrd, supp}, 2'b11);
    chk(pmaddr, 13'h0a34);
    @(posedge clk);
    instr <= 1'b1;
    #1;
    chk({pmrd, supp}, 2'b11);
    // No register access in the two instructions after the strobe.
    repeat (2) @(posedge clk);
    rc(`NVAC_SEL_DATA_LOW, 8'h68);
    rc(`NVAC_SEL_DATA_HIGH, 8'h20);
    rc(`NVAC_SEL_CONTROL, 8'h80);
    // Permit is stored first, so only the space bit can refuse the strobe.
    wr(`NVAC_SEL_CONTROL, 8'h84);
    arm(8'h55, 8'haa, 8'h86);
    rc(`NVAC_SEL_CONTROL, 8'h84);
    chk(busy, 1'b0);
    $display("test program read done");
    // A warm reset from each source in mid-write leaves only the abort flag set.
    for (int k = 0; k < 3; k++) begin
      wr(`NVAC_SEL_CONTROL, 8'h04);
      arm(8'h55, 8'haa, 8'h06);
      @(posedge clk);
      warm[k] <= 1'b1;
      repeat (4) @(posedge clk);
      warm <= 3'b000;
      repeat (4) @(posedge clk);
      rc(`NVAC_SEL_CONTROL, 8'h08);
      chk({busy, done}, 2'b00);
    end
    $display("test abort done");
    end_of_test();
  end
endmodule
